// File: src/orbt_pkg.sv
// Purpose: Shared constants for the octal registered bus transceiver.
// Assumes: 32-bit Avalon-MM register port, byte addresses.
// Notes:   Every offset and field position lives here, with the control register reset value.
package orbt_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned ORBT_DATA_W = 8;
    localparam int unsigned ORBT_ADDR_W = 4;
    localparam int unsigned ORBT_BUS_W = 32;
    localparam int unsigned ORBT_BE_W = 4;
    // Pins that cross into ref_clk: two clocks plus both ports
    localparam int unsigned ORBT_SYNC_W = 2 * ORBT_DATA_W + 2;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ORBT_ADDR_W-1:0] ORBT_CTRL_OFS = 4'h0;
    localparam logic [ORBT_ADDR_W-1:0] ORBT_STORE_OFS = 4'h4;
    localparam logic [ORBT_ADDR_W-1:0] ORBT_LIVE_OFS = 4'h8;

    // ------------------------------------------------------------------
    // Control register fields and reset value
    // ------------------------------------------------------------------
    localparam int unsigned ORBT_CTRL_W = 4;
    localparam int unsigned ORBT_CTRL_OE_N_BIT = 0;
    localparam int unsigned ORBT_CTRL_DIR_BIT = 1;
    localparam int unsigned ORBT_CTRL_SRC_A_BIT = 2;
    localparam int unsigned ORBT_CTRL_SRC_B_BIT = 3;
    // Isolation after reset: neither port driven
    localparam logic [ORBT_CTRL_W-1:0] ORBT_CTRL_RST = 4'h1;

    // ------------------------------------------------------------------
    // Field positions in the stored and live data registers
    // ------------------------------------------------------------------
    localparam int unsigned ORBT_LO_LSB = 0;
    localparam int unsigned ORBT_HI_LSB = 8;

    // Bus handshake state
    typedef enum logic [1:0] {
        ORBT_BUS_IDLE = 2'b01,
        ORBT_BUS_DONE = 2'b10
    } orbt_bus_e;

endpackage : orbt_pkg

// File: src/orbt_sync.sv
// Purpose: Two-stage synchroniser bank for asynchronous pins.
// Assumes: Each bit is an independent level; no bus coherence implied.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
module orbt_sync
    import orbt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [orbt_pkg::ORBT_SYNC_W-1:0] pin_async,
    output wire logic [orbt_pkg::ORBT_SYNC_W-1:0] pin_sync
);

    // ------------------------------------------------------------------
    // Per-bit two flip-flop chain
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < ORBT_SYNC_W; gi++)
        begin : g_bit
            logic meta_q;
            logic sync_q;
            // First stage may go metastable; only sync_q reads it
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else
                begin
                    meta_q <= pin_async[gi];
                    sync_q <= meta_q;
                end
            end
            assign pin_sync[gi] = sync_q;
        end
    endgenerate

endmodule : orbt_sync

// File: src/orbt_transceiver.sv
// Purpose: Octal registered bus transceiver between ports A and B.
// Assumes: Pins are asynchronous to ref_clk; capture clocks are slow
//          against ref_clk so each high and low phase spans two cycles.
// Notes:   Controls sit in an Avalon-MM register; storage has no reset.
`timescale 1ns/1ps
module orbt_transceiver
    import orbt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [orbt_pkg::ORBT_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [orbt_pkg::ORBT_BE_W-1:0] avs_byteenable,
    input wire logic [orbt_pkg::ORBT_BUS_W-1:0] avs_writedata,
    output logic [orbt_pkg::ORBT_BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Capture clocks arriving on pins
    input wire logic a_to_b_capture_clock,
    input wire logic b_to_a_capture_clock,
    // Port A two-way lines
    input wire logic [orbt_pkg::ORBT_DATA_W-1:0] port_a_lines_in,
    output logic [orbt_pkg::ORBT_DATA_W-1:0] port_a_lines_out,
    output logic port_a_lines_oe,
    // Port B two-way lines
    input wire logic [orbt_pkg::ORBT_DATA_W-1:0] port_b_lines_in,
    output logic [orbt_pkg::ORBT_DATA_W-1:0] port_b_lines_out,
    output logic port_b_lines_oe
);
    import orbt_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [ORBT_SYNC_W-1:0] pin_sync;
    logic ab_clk_s;
    logic ba_clk_s;
    logic [ORBT_DATA_W-1:0] a_s;
    logic [ORBT_DATA_W-1:0] b_s;
    logic ab_clk_d_q;
    logic ba_clk_d_q;
    logic ab_rise;
    logic ba_rise;
    logic [1:0] seen_q;
    logic [ORBT_DATA_W-1:0] ab_store_q;
    logic [ORBT_DATA_W-1:0] ba_store_q;
    logic [ORBT_CTRL_W-1:0] ctrl_q;
    logic oe_n;
    logic drive_b;
    logic src_a_stored;
    logic src_b_stored;
    logic drive_a_d;
    logic drive_b_d;
    logic [ORBT_DATA_W-1:0] a_out_d;
    logic [ORBT_DATA_W-1:0] b_out_d;
    orbt_bus_e bus_q;
    orbt_bus_e bus_d;
    logic bus_req;
    logic bus_take;
    logic sel_ctrl;
    logic sel_store;
    logic sel_live;
    logic ctrl_wr;
    logic [ORBT_BUS_W-1:0] rd_mux;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Clocks and data share one bank so a clock edge and the data
    // sampled with it stay aligned cycle for cycle
    orbt_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_async({a_to_b_capture_clock, b_to_a_capture_clock,
                    port_b_lines_in, port_a_lines_in}),
        .pin_sync(pin_sync)
    );

    assign a_s = pin_sync[ORBT_DATA_W-1:0];
    assign b_s = pin_sync[2*ORBT_DATA_W-1:ORBT_DATA_W];
    assign ba_clk_s = pin_sync[2*ORBT_DATA_W];
    assign ab_clk_s = pin_sync[2*ORBT_DATA_W+1];

    // ------------------------------------------------------------------
    // Capture clock edge detection
    // ------------------------------------------------------------------
    // Delayed copies of the synchronised capture clocks
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ab_clk_d_q <= 1'b0;
            ba_clk_d_q <= 1'b0;
            seen_q <= 2'b00;
        end
        else
        begin
            ab_clk_d_q <= ab_clk_s;
            ba_clk_d_q <= ba_clk_s;
            seen_q <= seen_q | {ab_rise, ba_rise}; // Stores now defined
        end
    end

    // A clock held high through reset release gives one edge, once the synchroniser fills
    assign ab_rise = ab_clk_s & ~ab_clk_d_q;
    assign ba_rise = ba_clk_s & ~ba_clk_d_q;

    // ------------------------------------------------------------------
    // Storage registers
    // ------------------------------------------------------------------
    // No reset: contents are whatever power-up left until first capture
    // Capture ignores every output control, and reads the pin whether
    // or not this block drives it
    always_ff @(posedge ref_clk)
    begin
        if (ab_rise)
        begin
            ab_store_q <= a_s;
        end
        if (ba_rise)
        begin
            ba_store_q <= b_s;
        end
    end

    // ------------------------------------------------------------------
    // Output control decode
    // ------------------------------------------------------------------
    assign oe_n = ctrl_q[ORBT_CTRL_OE_N_BIT];
    assign drive_b = ctrl_q[ORBT_CTRL_DIR_BIT];
    assign src_a_stored = ctrl_q[ORBT_CTRL_SRC_A_BIT];
    assign src_b_stored = ctrl_q[ORBT_CTRL_SRC_B_BIT];
    // One enable derives from the inverse of the other term
    assign drive_a_d = ~oe_n & ~drive_b;
    assign drive_b_d = ~oe_n & drive_b;
    // Live data is the synchronised opposite port, stored is the register
    assign a_out_d = src_a_stored ? ba_store_q : b_s;
    assign b_out_d = src_b_stored ? ab_store_q : a_s;

    // ------------------------------------------------------------------
    // Registered port drivers
    // ------------------------------------------------------------------
    // Data and enables leave from flops; live data lags the pin by three
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_a_lines_oe <= 1'b0;
            port_b_lines_oe <= 1'b0;
            port_a_lines_out <= '0;
            port_b_lines_out <= '0;
        end
        else
        begin
            port_a_lines_oe <= drive_a_d;
            port_b_lines_oe <= drive_b_d;
            port_a_lines_out <= a_out_d;
            port_b_lines_out <= b_out_d;
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------
    // Every access takes exactly one wait cycle; read data are loaded in
    // the wait cycle so they stand at the completing edge
    assign bus_req = avs_read | avs_write;
    assign bus_take = bus_req & (bus_q == ORBT_BUS_DONE);
    assign avs_waitrequest = bus_req & (bus_q == ORBT_BUS_IDLE);
    assign sel_ctrl = (avs_address == ORBT_CTRL_OFS);
    assign sel_store = (avs_address == ORBT_STORE_OFS);
    assign sel_live = (avs_address == ORBT_LIVE_OFS);
    assign ctrl_wr = bus_take & avs_write & sel_ctrl & avs_byteenable[0];

    // Unmapped addresses read zero; upper bits read zero
    assign rd_mux =
        sel_ctrl ? {{(ORBT_BUS_W-ORBT_CTRL_W){1'b0}}, ctrl_q} :
        sel_store ? {16'h0000, ba_store_q, ab_store_q} :
        sel_live ? {16'h0000, b_s, a_s} :
        32'h0000_0000;

    // Handshake sequencer
    always_comb
    begin
        bus_d = bus_q;
        unique case (bus_q)
            ORBT_BUS_IDLE:
            begin
                if (bus_req)
                begin
                    bus_d = ORBT_BUS_DONE;
                end
            end
            ORBT_BUS_DONE:
            begin
                bus_d = ORBT_BUS_IDLE;
            end
            default:
            begin
                bus_d = ORBT_BUS_IDLE;
            end
        endcase
    end

    // Bus state, read data and control register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_q <= ORBT_BUS_IDLE;
            avs_readdata <= '0;
            ctrl_q <= ORBT_CTRL_RST;
        end
        else
        begin
            bus_q <= bus_d;
            if (avs_read && bus_q == ORBT_BUS_IDLE)
            begin
                avs_readdata <= rd_mux;
            end
            if (ctrl_wr)
            begin
                ctrl_q <= avs_writedata[ORBT_CTRL_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_capture_ab;
        @(posedge ref_clk) disable iff (!rst_n)
        ab_rise |=> (ab_store_q == $past(a_s));
    endproperty
    a_capture_ab: assert property (p_capture_ab)
        else $error("A-to-B register missed a capture");
    property p_capture_ba;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(ba_clk_s) |=> (ba_store_q == $past(b_s));
    endproperty
    a_capture_ba: assert property (p_capture_ba)
        else $error("B-to-A register missed a capture");
    // Held only once both stores are defined; before that they are X
    property p_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (&seen_q && !ab_rise && !ba_rise) ##1 (!ab_rise && !ba_rise)
        |=> ($stable(ab_store_q) && $stable(ba_store_q));
    endproperty
    a_hold: assert property (p_hold)
        else $error("Storage changed with both clocks static");
    property p_isolate;
        @(posedge ref_clk) disable iff (!rst_n)
        oe_n |=> (!port_a_lines_oe && !port_b_lines_oe);
    endproperty
    a_isolate: assert property (p_isolate)
        else $error("Port driven while output enable is high");
    property p_direction;
        @(posedge ref_clk) disable iff (!rst_n)
        !oe_n |=> (port_a_lines_oe == !$past(drive_b))
                  && (port_b_lines_oe == $past(drive_b));
    endproperty
    a_direction: assert property (p_direction)
        else $error("Wrong port driven for the drive select");
    property p_live_to_a;
        @(posedge ref_clk) disable iff (!rst_n)
        (drive_a_d && !src_a_stored) |=>
            (port_a_lines_oe && port_a_lines_out == $past(b_s, 1));
    endproperty
    a_live_to_a: assert property (p_live_to_a)
        else $error("Port A does not show live port B data");
    property p_stored_to_a;
        @(posedge ref_clk) disable iff (!rst_n)
        (drive_a_d && src_a_stored) |=>
            (port_a_lines_out == $past(ba_store_q));
    endproperty
    a_stored_to_a: assert property (p_stored_to_a)
        else $error("Port A does not show the B-to-A register");
    property p_live_to_b;
        @(posedge ref_clk) disable iff (!rst_n)
        (drive_b_d && !src_b_stored) |=>
            (port_b_lines_oe && port_b_lines_out == $past(a_s, 1));
    endproperty
    a_live_to_b: assert property (p_live_to_b)
        else $error("Port B does not show live port A data");
    property p_stored_to_b;
        @(posedge ref_clk) disable iff (!rst_n)
        (drive_b_d && src_b_stored) |=>
            (port_b_lines_out == $past(ab_store_q));
    endproperty
    a_stored_to_b: assert property (p_stored_to_b)
        else $error("Port B does not show the A-to-B register");
    property p_one_driver;
        @(posedge ref_clk) disable iff (!rst_n)
        !(port_a_lines_oe && port_b_lines_oe);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("Both ports driven together");
    property p_undriven_input;
        @(posedge ref_clk) disable iff (!rst_n)
        (port_b_lines_oe && ab_rise && ba_rise) |=>
            (ab_store_q == $past(a_s)) && (ba_store_q == $past(b_s));
    endproperty
    a_undriven_input: assert property (p_undriven_input)
        else $error("Undriven port data not stored");

    property p_bus_wait;
        @(posedge ref_clk) disable iff (!rst_n)
        (bus_req && bus_q == ORBT_BUS_IDLE) |=> !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("Bus access not answered after one wait");

    // Main scenarios
    c_stored_b_to_a: cover property (@(posedge ref_clk) disable iff (!rst_n)
        drive_a_d && src_a_stored ##1 ba_rise);
    c_live_a_to_b: cover property (@(posedge ref_clk) disable iff (!rst_n)
        drive_b_d && !src_b_stored && ab_rise);
    c_isolate_both: cover property (@(posedge ref_clk) disable iff (!rst_n)
        oe_n && ab_rise && ba_rise);

endmodule : orbt_transceiver

// File: testbench/orbt_bus_partner.sv
// Purpose: Far-side system logic on ports A and B with capture clocks.
// Assumes: Its tasks are called right after a rising ref_clk edge.
// Notes:   A line nobody drives toggles every cycle, never holds.
`timescale 1ns/1ps
module orbt_bus_partner
    import orbt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [orbt_pkg::ORBT_DATA_W-1:0] a_out,
    input wire logic a_oe,
    input wire logic [orbt_pkg::ORBT_DATA_W-1:0] b_out,
    input wire logic b_oe,
    output logic [orbt_pkg::ORBT_DATA_W-1:0] a_wire,
    output logic [orbt_pkg::ORBT_DATA_W-1:0] b_wire,
    output logic ab_clk,
    output logic ba_clk
);
    import orbt_pkg::*;

    logic [ORBT_DATA_W-1:0] a_val_q = 8'h00;
    logic [ORBT_DATA_W-1:0] b_val_q = 8'h00;
    logic a_en_q = 1'b1;
    logic b_en_q = 1'b1;
    logic [ORBT_DATA_W-1:0] float_q = 8'h55;

    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    // Two drivers give unknown, so a clash cannot hide
    assign a_wire = (a_oe & a_en_q) ? 8'hxx : a_oe ? a_out :
                    a_en_q ? a_val_q : float_q;
    assign b_wire = (b_oe & b_en_q) ? 8'hxx : b_oe ? b_out :
                    b_en_q ? b_val_q : float_q;

    // Floating lines must not look like the last driven value
    always @(posedge ref_clk)
        float_q <= ~float_q;

    // Set what system logic puts on each bus, and whether it drives
    task drive(input logic [7:0] a, input logic ae, input logic [7:0] b,
               input logic be);
        a_val_q <= a;
        a_en_q <= ae;
        b_val_q <= b;
        b_en_q <= be;
    endtask : drive

    // Phases of four cycles keep data stable around the rising edge
    task pulse(input logic ab, input logic ba);
        repeat (4) @(posedge ref_clk);
        ab_clk <= ab;
        ba_clk <= ba;
        repeat (4) @(posedge ref_clk);
        ab_clk <= 1'b0;
        ba_clk <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : pulse

    initial
    begin
        ab_clk = 1'b0;
        ba_clk = 1'b0;
    end
endmodule : orbt_bus_partner

// File: testbench/tb_octal_registered_bus_transceiver.sv
// Purpose: Self-checking bench for the registered bus transceiver.
// Assumes: Bus master waits for waitrequest low; captures land 3 edges after the clock pin rises.
// Notes:   Storage is unknown until captured, so it is read after.
`timescale 1ns/1ps
module tb_octal_registered_bus_transceiver;
    import orbt_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ORBT_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [ORBT_BE_W-1:0] avs_byteenable = '0;
    logic [ORBT_BUS_W-1:0] avs_writedata = '0;
    logic [ORBT_BUS_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic ab_clk, ba_clk, a_oe, b_oe;
    logic [ORBT_DATA_W-1:0] a_in, a_out, b_in, b_out;
    logic [31:0] rd;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;

    always #50 ref_clk = ~ref_clk;

    orbt_transceiver uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .a_to_b_capture_clock(ab_clk), .b_to_a_capture_clock(ba_clk),
        .port_a_lines_in(a_in), .port_a_lines_out(a_out),
        .port_a_lines_oe(a_oe), .port_b_lines_in(b_in),
        .port_b_lines_out(b_out), .port_b_lines_oe(b_oe));

    orbt_bus_partner p (.ref_clk(ref_clk), .a_out(a_out), .a_oe(a_oe),
        .b_out(b_out), .b_oe(b_oe), .a_wire(a_in), .b_wire(b_in),
        .ab_clk(ab_clk), .ba_clk(ba_clk));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task results;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // A hang costs a mismatch and still reaches the verdict
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            results;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Sampled at the falling edge, where outputs have settled
    task chk_ports(input logic [1:0] oe, input logic [7:0] v);
        @(negedge ref_clk);
        chk({30'h0, a_oe, b_oe}, {30'h0, oe});
        if (oe[1])
            chk({24'h0, a_out}, {24'h0, v});
        if (oe[0])
            chk({24'h0, b_out}, {24'h0, v});
        @(posedge ref_clk);
    endtask : chk_ports

    // Request holds until waitrequest is sampled low at a rising edge;
    // read data are taken at that edge, a hang is left to the timeout
    task av(input logic w, input logic [3:0] a, input logic [31:0] wd,
            input logic [3:0] be, output logic [31:0] d);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= ~w;
        avs_write <= w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge ref_clk);
        end
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : av

    task av_wr(input logic [3:0] a, input logic [31:0] wd,
               input logic [3:0] be);
        logic [31:0] unused;
        av(1'b1, a, wd, be, unused);
    endtask : av_wr

    task av_rd(input logic [3:0] a, output logic [31:0] d);
        av(1'b0, a, 32'h0, 4'hf, d);
    endtask : av_rd

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_regs;
        av_rd(ORBT_CTRL_OFS, rd);
        chk(rd, 32'h1);
        chk_ports(2'b00, 8'h00);
        av_wr(4'hc, 32'h0, 4'hf);
        av_wr(ORBT_CTRL_OFS, 32'h0, 4'h0);
        av_rd(ORBT_CTRL_OFS, rd);
        chk(rd, 32'h1);
        av_rd(4'hc, rd);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task t_isolate;
        p.drive(8'ha5, 1'b1, 8'h3c, 1'b1);
        p.pulse(1'b1, 1'b1);
        av_rd(ORBT_STORE_OFS, rd);
        chk(rd, 32'h3ca5);
        chk_ports(2'b00, 8'h00);
        p.drive(8'h11, 1'b1, 8'h22, 1'b1);
        repeat (8) @(posedge ref_clk);
        av_rd(ORBT_STORE_OFS, rd);
        chk(rd, 32'h3ca5);
        av_rd(ORBT_LIVE_OFS, rd);
        chk(rd, 32'h2211);
        p.pulse(1'b1, 1'b0);
        av_rd(ORBT_STORE_OFS, rd);
        chk(rd, 32'h3c11);
        $display("test isolate done");
    endtask : t_isolate

    task t_live_a;
        p.drive(8'h00, 1'b0, 8'h5a, 1'b1);
        av_wr(ORBT_CTRL_OFS, 32'h0, 4'hf);
        repeat (5) @(posedge ref_clk);
        chk_ports(2'b10, 8'h5a);
        p.drive(8'h00, 1'b0, 8'h81, 1'b1);
        repeat (5) @(posedge ref_clk);
        chk_ports(2'b10, 8'h81);
        p.pulse(1'b1, 1'b1);
        av_rd(ORBT_STORE_OFS, rd);
        chk(rd, 32'h8181);
        $display("test live a done");
    endtask : t_live_a

    task t_stored_a;
        p.drive(8'h00, 1'b0, 8'h3e, 1'b1);
        av_wr(ORBT_CTRL_OFS, 32'h4, 4'hf);
        repeat (5) @(posedge ref_clk);
        chk_ports(2'b10, 8'h81);
        p.pulse(1'b0, 1'b1);
        chk_ports(2'b10, 8'h3e);
        $display("test stored a done");
    endtask : t_stored_a

    task t_live_b;
        // Let go of B before the block turns to drive it, and take A
        // only once the block has let go of A, so no bus ever clashes
        p.drive(8'h00, 1'b0, 8'h00, 1'b0);
        av_wr(ORBT_CTRL_OFS, 32'h2, 4'hf);
        p.drive(8'h96, 1'b1, 8'h00, 1'b0);
        repeat (5) @(posedge ref_clk);
        chk_ports(2'b01, 8'h96);
        p.pulse(1'b1, 1'b1);
        av_rd(ORBT_STORE_OFS, rd);
        chk(rd, 32'h9696);
        $display("test live b done");
    endtask : t_live_b

    task t_stored_b;
        p.drive(8'h69, 1'b1, 8'h00, 1'b0);
        av_wr(ORBT_CTRL_OFS, 32'ha, 4'hf);
        repeat (5) @(posedge ref_clk);
        chk_ports(2'b01, 8'h96);
        p.pulse(1'b1, 1'b0);
        chk_ports(2'b01, 8'h69);
        av_wr(ORBT_CTRL_OFS, 32'h1, 4'hf);
        repeat (2) @(posedge ref_clk);
        chk_ports(2'b00, 8'h00);
        $display("test stored b done");
    endtask : t_stored_b

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs;
        t_isolate;
        t_live_a;
        t_stored_a;
        t_live_b;
        t_stored_b;
        results;
    end
endmodule : tb_octal_registered_bus_transceiver
